//--- rtl/input_capture_channel.sv
/*
  One input capture channel with a parameterised-depth capture buffer,
  Avalon-MM register slave and a masked level interrupt.
  Assumes the capture pin and timer counts are synchronous to i_clk.
*/
// Chosen here: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module input_capture_channel #(
  parameter int DEPTH = 4,
  parameter int WIDTH = 16
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Avalon-MM slave
  input wire logic [3:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  // Capture pin and timer bases
  input wire logic i_capture_input_pin,
  input wire logic [WIDTH-1:0] i_first_timer_base_count,
  input wire logic [WIDTH-1:0] i_second_timer_base_count,
  // Power state
  input wire logic i_cpu_idle,
  input wire logic i_cpu_sleep,
  // Events out
  output logic o_irq,
  output logic o_wake
);
  localparam int PW = $clog2(DEPTH);

  capture_pkg::avalon_req_t req;
  assign req = '{address: i_address, read: i_read, write: i_write,
                 writedata: i_writedata, byteenable: i_byteenable};

  // Register state
  logic idle_stop_select_r, idle_stop_select_nxt;
  logic timer_base_select_r, timer_base_select_nxt;
  logic [1:0] interrupt_rate_field_r, interrupt_rate_field_nxt;
  logic [2:0] capture_mode_field_r, capture_mode_field_nxt;
  logic capture_overflow_flag_r, capture_overflow_flag_nxt;
  logic [capture_pkg::EVT_W-1:0] irq_status_r, irq_status_nxt;
  logic [capture_pkg::EVT_W-1:0] irq_mask_r, irq_mask_nxt;
  logic [31:0] readdata_r, readdata_nxt;
  logic waitrequest_r, waitrequest_nxt;
  logic irq_r, irq_nxt;
  logic wake_r, wake_nxt;
  // Capture path state
  logic pin_prev_r, pin_prev_nxt;
  logic [3:0] prescale_r, prescale_nxt;
  logic [1:0] rate_cnt_r, rate_cnt_nxt;
  // Own buffer per channel instance
  logic [WIDTH-1:0] fifo_mem_r [DEPTH];
  logic [PW-1:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
  logic [PW:0] count_r, count_nxt;

  // Pointer advance with wrap
  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction : ptr_inc

  // Edge detection and enables
  logic rise, fall, halted, active, capture_evt, wake_evt, push, pop, accepted;
  logic rd_buf, wr_ctl, wr_sts, wr_msk;
  logic [15:0] control_view;
  capture_pkg::capture_mode_t mode;
  assign mode = capture_pkg::capture_mode_t'(capture_mode_field_r);
  assign rise = i_capture_input_pin & ~pin_prev_r;
  assign fall = ~i_capture_input_pin & pin_prev_r;
  assign halted = idle_stop_select_r & i_cpu_idle;
  assign active = ~halted & ~i_cpu_sleep;
  // Accept each request in the cycle it rises, one access at a time
  assign accepted = waitrequest_r & (req.read | req.write);
  assign rd_buf = accepted & req.read & (req.address == capture_pkg::ADDR_BUFFER);
  assign wr_ctl = accepted & req.write & (req.address == capture_pkg::ADDR_CONTROL);
  assign wr_sts = accepted & req.write & (req.address == capture_pkg::ADDR_STATUS) & req.byteenable[0];
  assign wr_msk = accepted & req.write & (req.address == capture_pkg::ADDR_MASK) & req.byteenable[0];
  assign pop = rd_buf & (count_r != '0);
  assign push = capture_evt & (count_r != (PW + 1)'(DEPTH));

  // Capture event selection by mode
  always_comb
  begin
    capture_evt = 1'b0;
    wake_evt = 1'b0;
    prescale_nxt = prescale_r;
    case (mode)
      capture_pkg::MODE_EVERY_EDGE: capture_evt = active & (rise | fall);
      capture_pkg::MODE_FALLING: capture_evt = active & fall;
      capture_pkg::MODE_RISING: capture_evt = active & rise;
      capture_pkg::MODE_RISE_4, capture_pkg::MODE_RISE_16:
      begin
        if (active & rise)
        begin
          if (prescale_r == ((mode == capture_pkg::MODE_RISE_4) ? capture_pkg::PRESCALE_4
                             : capture_pkg::PRESCALE_16))
          begin
            capture_evt = 1'b1;
            prescale_nxt = '0;
          end
          else
          begin
            prescale_nxt = prescale_r + 4'h1;
          end
        end
      end
      capture_pkg::MODE_WAKE_ONLY: wake_evt = rise & (i_cpu_sleep | i_cpu_idle);
      default: prescale_nxt = '0;
    endcase
    if (mode != capture_pkg::MODE_WAKE_ONLY && capture_evt && (i_cpu_sleep | i_cpu_idle))
    begin
      wake_evt = 1'b1;
    end
    if (wr_ctl)
    begin
      prescale_nxt = '0;
    end
  end

  // Buffer and counters next state
  logic rate_hit;
  always_comb
  begin
    wr_ptr_nxt = wr_ptr_r;
    rd_ptr_nxt = rd_ptr_r;
    count_nxt = count_r;
    rate_nxt_default:
    begin
      rate_cnt_nxt = rate_cnt_r;
    end
    rate_hit = 1'b0;
    if (push)
    begin
      wr_ptr_nxt = ptr_inc(wr_ptr_r);
    end
    if (pop)
    begin
      rd_ptr_nxt = ptr_inc(rd_ptr_r);
    end
    count_nxt = count_r + (PW + 1)'(push) - (PW + 1)'(pop);
    if (capture_evt)
    begin
      if (mode == capture_pkg::MODE_EVERY_EDGE)
      begin
        rate_hit = 1'b1;
      end
      else if (rate_cnt_r == interrupt_rate_field_r)
      begin
        rate_hit = 1'b1;
        rate_cnt_nxt = '0;
      end
      else
      begin
        rate_cnt_nxt = rate_cnt_r + 2'h1;
      end
    end
    if (wr_ctl)
    begin
      rate_cnt_nxt = '0;
    end
  end

  // Register file next state
  always_comb
  begin
    idle_stop_select_nxt = idle_stop_select_r;
    timer_base_select_nxt = timer_base_select_r;
    interrupt_rate_field_nxt = interrupt_rate_field_r;
    capture_mode_field_nxt = capture_mode_field_r;
    irq_mask_nxt = irq_mask_r;
    capture_overflow_flag_nxt = capture_overflow_flag_r;
    irq_status_nxt = irq_status_r;
    if (wr_ctl && req.byteenable[0])
    begin
      timer_base_select_nxt = req.writedata[capture_pkg::POS_TIMER_SEL];
      interrupt_rate_field_nxt = req.writedata[capture_pkg::POS_RATE_LO +: 2];
      capture_mode_field_nxt = req.writedata[capture_pkg::POS_MODE_LO +: 3];
    end
    if (wr_ctl && req.byteenable[1])
    begin
      idle_stop_select_nxt = req.writedata[capture_pkg::POS_IDLE_STOP];
    end
    if (wr_msk)
    begin
      irq_mask_nxt = req.writedata[capture_pkg::EVT_W-1:0];
    end
    // Overflow clears once buffer fully drained
    if (count_nxt == '0)
    begin
      capture_overflow_flag_nxt = 1'b0;
    end
    if (capture_evt && !push)
    begin
      capture_overflow_flag_nxt = 1'b1;
    end
    // Write-one-to-clear, set wins
    if (wr_sts)
    begin
      irq_status_nxt = irq_status_r & ~req.writedata[capture_pkg::EVT_W-1:0];
    end
    if (rate_hit)
    begin
      irq_status_nxt[capture_pkg::EVT_CAPTURE] = 1'b1;
    end
    if (capture_evt && !push)
    begin
      irq_status_nxt[capture_pkg::EVT_OVERFLOW] = 1'b1;
    end
    if (wake_evt)
    begin
      irq_status_nxt[capture_pkg::EVT_WAKE] = 1'b1;
    end
    irq_nxt = |(irq_status_nxt & irq_mask_nxt);
    wake_nxt = wake_evt;
    pin_prev_nxt = i_capture_input_pin;
  end

  // Bus answer next state
  always_comb
  begin
    control_view = '0;
    control_view[capture_pkg::POS_IDLE_STOP] = idle_stop_select_r;
    control_view[capture_pkg::POS_TIMER_SEL] = timer_base_select_r;
    control_view[capture_pkg::POS_RATE_LO +: 2] = interrupt_rate_field_r;
    control_view[capture_pkg::POS_OVERFLOW] = capture_overflow_flag_r;
    control_view[capture_pkg::POS_NOT_EMPTY] = (count_r != '0);
    control_view[capture_pkg::POS_MODE_LO +: 3] = capture_mode_field_r;
    readdata_nxt = readdata_r;
    waitrequest_nxt = 1'b1;
    if (accepted)
    begin
      waitrequest_nxt = 1'b0;
      readdata_nxt = capture_pkg::UNMAPPED_DATA;
      if (req.read)
      begin
        case (req.address)
          capture_pkg::ADDR_CONTROL: readdata_nxt = {16'h0000, control_view};
          capture_pkg::ADDR_BUFFER: readdata_nxt = (count_r != '0) ? 32'(fifo_mem_r[rd_ptr_r]) : 32'h0000_0000;
          capture_pkg::ADDR_STATUS: readdata_nxt = 32'(irq_status_r);
          capture_pkg::ADDR_MASK: readdata_nxt = 32'(irq_mask_r);
          default: readdata_nxt = capture_pkg::UNMAPPED_DATA;
        endcase
      end
    end
  end

  // Buffer storage, selected timer latched on push
  always_ff @(posedge i_clk)
  begin
    if (push)
    begin
      fifo_mem_r[wr_ptr_r] <= timer_base_select_r ? i_first_timer_base_count
                                                  : i_second_timer_base_count;
    end
  end

  // State registers
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      idle_stop_select_r <= 1'b0;
      timer_base_select_r <= 1'b0;
      interrupt_rate_field_r <= 2'b00;
      capture_mode_field_r <= capture_pkg::MODE_OFF;
      capture_overflow_flag_r <= 1'b0;
      irq_status_r <= '0;
      irq_mask_r <= '0;
      readdata_r <= '0;
      waitrequest_r <= 1'b1;
      irq_r <= 1'b0;
      wake_r <= 1'b0;
      pin_prev_r <= 1'b0;
      prescale_r <= '0;
      rate_cnt_r <= '0;
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end
    else
    begin
      idle_stop_select_r <= idle_stop_select_nxt;
      timer_base_select_r <= timer_base_select_nxt;
      interrupt_rate_field_r <= interrupt_rate_field_nxt;
      capture_mode_field_r <= capture_mode_field_nxt;
      capture_overflow_flag_r <= capture_overflow_flag_nxt;
      irq_status_r <= irq_status_nxt;
      irq_mask_r <= irq_mask_nxt;
      readdata_r <= readdata_nxt;
      waitrequest_r <= waitrequest_nxt;
      irq_r <= irq_nxt;
      wake_r <= wake_nxt;
      pin_prev_r <= pin_prev_nxt;
      prescale_r <= prescale_nxt;
      rate_cnt_r <= rate_cnt_nxt;
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      count_r <= count_nxt;
    end
  end

  assign o_readdata = readdata_r;
  assign o_waitrequest = waitrequest_r;
  assign o_irq = irq_r;
  assign o_wake = wake_r;

  // Checks
  sequence s_full_capture;
    capture_evt && (count_r == (PW + 1)'(DEPTH));
  endsequence

  a_overflow_on_full: assert property (@(posedge i_clk) disable iff (!i_resetn)
    s_full_capture |=> capture_overflow_flag_r && ($stable(count_r) || $past(pop)))
    else $error("overflow not flagged on full capture");
  a_off_no_capture: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (mode == capture_pkg::MODE_OFF || mode == capture_pkg::MODE_UNUSED) |-> !capture_evt)
    else $error("capture while disabled");
  a_edge_both: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (mode == capture_pkg::MODE_EVERY_EDGE && active && i_capture_input_pin != pin_prev_r) |-> capture_evt)
    else $error("every-edge capture missed");
  a_falling_only: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (mode == capture_pkg::MODE_FALLING && capture_evt) |-> (pin_prev_r && !i_capture_input_pin))
    else $error("falling mode captured wrong edge");
  a_not_empty_flag: assert property (@(posedge i_clk) disable iff (!i_resetn)
    push && !pop |=> control_view[capture_pkg::POS_NOT_EMPTY])
    else $error("not-empty flag low after push");
  a_idle_halt: assert property (@(posedge i_clk) disable iff (!i_resetn)
    halted |-> !capture_evt)
    else $error("capture while halted in idle");
  a_every_edge_irq: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (mode == capture_pkg::MODE_EVERY_EDGE && capture_evt) |=> irq_status_r[capture_pkg::EVT_CAPTURE])
    else $error("every-edge capture did not flag");
  a_wake_pulse: assert property (@(posedge i_clk) disable iff (!i_resetn)
    wake_evt |=> o_wake)
    else $error("wake pulse missing");
  a_rate_first: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (capture_evt && mode != capture_pkg::MODE_EVERY_EDGE && interrupt_rate_field_r == 2'b00)
    |=> irq_status_r[capture_pkg::EVT_CAPTURE])
    else $error("rate 00 did not flag every capture");
  a_read_oldest: assert property (@(posedge i_clk) disable iff (!i_resetn)
    pop |=> o_readdata[WIDTH-1:0] == $past(fifo_mem_r[rd_ptr_r]))
    else $error("read did not return oldest entry");
  a_capture_source: assert property (@(posedge i_clk) disable iff (!i_resetn)
    push |=> fifo_mem_r[$past(wr_ptr_r)] == ($past(timer_base_select_r) ? $past(i_first_timer_base_count)
                                                                          : $past(i_second_timer_base_count)))
    else $error("captured value not from selected timer");
  a_prescale_count: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (capture_evt && mode == capture_pkg::MODE_RISE_16) |-> (rise && prescale_r == capture_pkg::PRESCALE_16))
    else $error("prescaled capture on wrong edge count");
  a_wake_only_quiet: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (mode == capture_pkg::MODE_WAKE_ONLY) |-> (!capture_evt && !push))
    else $error("capture in interrupt-only mode");
endmodule : input_capture_channel

//--- rtl/capture_pkg.sv
/*
  Shared constants and bus carrier types for the input capture channel.
  Assumes a single 100 MHz clock and a 32-bit Avalon-MM register slave.
*/
package capture_pkg;
  // Register byte addresses
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_BUFFER = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam logic [3:0] ADDR_MASK = 4'hC;
  // Control field positions
  localparam int POS_IDLE_STOP = 13;
  localparam int POS_TIMER_SEL = 7;
  localparam int POS_RATE_LO = 5;
  localparam int POS_OVERFLOW = 4;
  localparam int POS_NOT_EMPTY = 3;
  localparam int POS_MODE_LO = 0;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [15:0] CONTROL_WMASK = 16'h20E7;
  // Interrupt status bits
  localparam int EVT_CAPTURE = 0;
  localparam int EVT_OVERFLOW = 1;
  localparam int EVT_WAKE = 2;
  localparam int EVT_W = 3;
  // Prescale counts
  localparam logic [3:0] PRESCALE_4 = 4'h3;
  localparam logic [3:0] PRESCALE_16 = 4'hF;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

  typedef enum logic [2:0] {
    MODE_OFF = 3'b000,
    MODE_EVERY_EDGE = 3'b001,
    MODE_FALLING = 3'b010,
    MODE_RISING = 3'b011,
    MODE_RISE_4 = 3'b100,
    MODE_RISE_16 = 3'b101,
    MODE_UNUSED = 3'b110,
    MODE_WAKE_ONLY = 3'b111
  } capture_mode_t;

  typedef struct packed {
    logic [3:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } avalon_req_t;
endpackage : capture_pkg

//--- testbench/pulse_source.sv
/*
  Model of the external pulse source that drives the capture pin.
  Assumes the bench raises i_go for one cycle with i_pulses set, and waits for o_busy to fall.
*/
`timescale 1ns/1ps
module pulse_source (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Burst request
  input wire logic i_go,
  input wire logic [4:0] i_pulses,
  // Pin and status
  output logic o_pin,
  output logic o_busy
);
  logic [5:0] halves_r;
  logic [1:0] dwell_r;

  // Each pin level holds three cycles, burst ends low
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_pin <= 1'b0;
      halves_r <= 6'h00;
      dwell_r <= 2'h0;
    end
    else if (halves_r == 6'h00)
    begin
      if (i_go)
      begin
        halves_r <= {i_pulses, 1'b0};
        dwell_r <= 2'h2;
      end
    end
    else if (dwell_r == 2'h0)
    begin
      o_pin <= ~o_pin;
      halves_r <= halves_r - 6'h01;
      dwell_r <= 2'h2;
    end
    else
      dwell_r <= dwell_r - 2'h1;
  end

  // Busy while edges remain
  assign o_busy = (halves_r != 6'h00);
endmodule : pulse_source

//--- testbench/input_capture_channel_tb.sv
/*
  Self-checking bench for the input capture channel.
  Assumes one 100 MHz clock, the pulse source model on the pin and an Avalon-MM register slave.
*/
`timescale 1ns/1ps
module input_capture_channel_tb;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] addr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata;
  logic wreq;
  logic pin;
  logic [15:0] first = 16'h0000;
  logic [15:0] second = 16'h0000;
  logic [15:0] fv;
  logic [15:0] sv;
  logic [15:0] vals [4];
  logic idle = 1'b0;
  logic sleep = 1'b0;
  logic irq;
  logic wake;
  logic go = 1'b0;
  logic [4:0] npulse = 5'h01;
  logic busy;
  logic [31:0] q;
  int fails = 0;
  int checks_done = 0;
  int wakes = 0;
  int w0;
  integer seed = 32'h286c_de1c;

  // Clock and wake pulse counter
  always #5 clk = ~clk;
  always @(posedge clk) if (wake === 1'b1) wakes++;

  input_capture_channel #(.DEPTH(4), .WIDTH(16)) input_capture_channel_inst (
    .i_clk(clk), .i_resetn(resetn), .i_address(addr), .i_read(rd), .i_write(wr),
    .i_writedata(wdata), .i_byteenable(4'hF), .o_readdata(rdata), .o_waitrequest(wreq),
    .i_capture_input_pin(pin), .i_first_timer_base_count(first), .i_second_timer_base_count(second),
    .i_cpu_idle(idle), .i_cpu_sleep(sleep), .o_irq(irq), .o_wake(wake));

  pulse_source pulse_source_inst (.i_clk(clk), .i_resetn(resetn), .i_go(go), .i_pulses(npulse),
    .o_pin(pin), .o_busy(busy));

  // Run end: counts, verdict, stop
  task automatic close_out;
  begin
    $display("Checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask : close_out

  // One Avalon access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
  begin
    @(posedge clk);
    addr <= a;
    wr <= w;
    rd <= ~w;
    wdata <= d;
    @(posedge clk);
    // Waitrequest seen low ends this wait, or else the watchdog ends the run
    while (wreq !== 1'b0)
    begin
      @(posedge clk);
    end
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  end
  endtask : bus

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
  begin
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask : cmp

  // Burst of pin pulses with timer counts held at fv and sv
  task automatic pulses(input logic [4:0] n);
  begin
    @(posedge clk);
    first <= fv;
    second <= sv;
    npulse <= n;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    while (busy === 1'b1)
    begin
      @(posedge clk);
    end
    repeat (4) @(posedge clk);
  end
  endtask : pulses

  task automatic drain;
  begin
    for (int k = 0; k < 4; k++)
    begin
      bus(1'b0, capture_pkg::ADDR_BUFFER, 32'h0000_0000);
    end
    bus(1'b0, capture_pkg::ADDR_CONTROL, 32'h0000_0000);
    cmp(32'(q[capture_pkg::POS_NOT_EMPTY]), 32'h0000_0000);
  end
  endtask : drain

  // Control word from fields
  function automatic logic [31:0] ctl(input logic is, input logic ts, input logic [1:0] r, input logic [2:0] m);
    return 32'({is, 5'h00, ts, r, 2'b00, m});
  endfunction : ctl

  // Watchdog
  initial
  begin
    #300000;
    fails++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    close_out();
  end

  // Main sequence
  initial
  begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    bus(1'b0, capture_pkg::ADDR_CONTROL, 32'h0000_0000);
    cmp(q, 32'(capture_pkg::CONTROL_RESET));
    bus(1'b0, capture_pkg::ADDR_STATUS, 32'h0000_0000);
    cmp(q | 32'(irq), 32'h0000_0000);
    bus(1'b0, 4'h2, 32'h0000_0000);
    cmp(q, capture_pkg::UNMAPPED_DATA);
    bus(1'b1, capture_pkg::ADDR_MASK, 32'h0000_0007);
    // Simple modes on both timer bases
    for (int i = 0; i < 4; i++)
    begin
      fv = 16'($random(seed));
      sv = ~fv;
      bus(1'b1, capture_pkg::ADDR_CONTROL, ctl(1'b0, i[0], 2'h0, (i < 2) ? 3'b011 : 3'b010));
      pulses(5'h01);
      bus(1'b0, capture_pkg::ADDR_BUFFER, 32'h0000_0000);
      cmp(q, {16'h0000, i[0] ? fv : sv});
      bus(1'b0, capture_pkg::ADDR_CONTROL, 32'h0000_0000);
      cmp(32'(q[capture_pkg::POS_NOT_EMPTY]), 32'h0000_0000);
    end
    // Every edge: rate field ignored
    bus(1'b1, capture_pkg::ADDR_CONTROL, ctl(1'b0, 1'b1, 2'h3, capture_pkg::MODE_EVERY_EDGE));
    bus(1'b1, capture_pkg::ADDR_STATUS, 32'h0000_0007);
    pulses(5'h01);
    cmp(32'(irq), 32'h0000_0001);
    for (int i = 0; i < 3; i++)
    begin
      bus(1'b0, capture_pkg::ADDR_BUFFER, 32'h0000_0000);
      cmp(q, (i < 2) ? {16'h0000, fv} : 32'h0000_0000);
    end
    // Off and unused modes
    for (int j = 0; j < 2; j++)
    begin
      bus(1'b1, capture_pkg::ADDR_CONTROL, ctl(1'b0, 1'b1, 2'h0, j ? 3'b110 : 3'b000));
      pulses(5'h02);
      bus(1'b0, capture_pkg::ADDR_CONTROL, 32'h0000_0000);
      cmp(32'(q[capture_pkg::POS_NOT_EMPTY]), 32'h0000_0000);
    end
    // Five captures into a four-deep buffer
    bus(1'b1, capture_pkg::ADDR_CONTROL, ctl(1'b0, 1'b1, 2'h0, capture_pkg::MODE_RISING));
    for (int k = 0; k < 5; k++)
    begin
      fv = 16'($random(seed));
      sv = 16'($random(seed));
      if (k < 4) vals[k] = fv;
      pulses(5'h01);
    end
    bus(1'b0, capture_pkg::ADDR_CONTROL, 32'h0000_0000);
    cmp(32'(q[4:3]), 32'h0000_0003);
    for (int k = 0; k < 4; k++)
    begin
      bus(1'b0, capture_pkg::ADDR_BUFFER, 32'h0000_0000);
      cmp(q, {16'h0000, vals[k]});
    end
    bus(1'b0, capture_pkg::ADDR_CONTROL, 32'h0000_0000);
    cmp(32'(q[4:3]), 32'h0000_0000);
    // Interrupt rate, then masking
    for (int r = 0; r < 4; r++)
    begin
      bus(1'b1, capture_pkg::ADDR_CONTROL, ctl(1'b0, 1'b1, 2'(r), capture_pkg::MODE_RISING));
      bus(1'b1, capture_pkg::ADDR_STATUS, 32'h0000_0007);
      for (int k = 0; k < r; k++) pulses(5'h01);
      cmp(32'(irq), 32'h0000_0000);
      pulses(5'h01);
      cmp(32'(irq), 32'h0000_0001);
      drain();
    end
    bus(1'b1, capture_pkg::ADDR_MASK, 32'h0000_0000);
    repeat (2) @(posedge clk);
    cmp(32'(irq), 32'h0000_0000);
    bus(1'b1, capture_pkg::ADDR_MASK, 32'h0000_0007);
    // Prescaled modes
    for (int j = 0; j < 2; j++)
    begin
      bus(1'b1, capture_pkg::ADDR_CONTROL, ctl(1'b0, 1'b1, 2'h0, j ? 3'b101 : 3'b100));
      pulses(j ? 5'h0F : 5'h03);
      bus(1'b0, capture_pkg::ADDR_CONTROL, 32'h0000_0000);
      cmp(32'(q[capture_pkg::POS_NOT_EMPTY]), 32'h0000_0000);
      fv = 16'($random(seed));
      pulses(5'h01);
      bus(1'b0, capture_pkg::ADDR_BUFFER, 32'h0000_0000);
      cmp(q, {16'h0000, fv});
    end
    // Idle stop, wake from idle and sleep
    @(posedge clk);
    idle <= 1'b1;
    bus(1'b1, capture_pkg::ADDR_CONTROL, ctl(1'b1, 1'b1, 2'h0, capture_pkg::MODE_RISING));
    pulses(5'h01);
    bus(1'b0, capture_pkg::ADDR_CONTROL, 32'h0000_0000);
    cmp(32'(q[capture_pkg::POS_NOT_EMPTY]), 32'h0000_0000);
    w0 = wakes;
    bus(1'b1, capture_pkg::ADDR_CONTROL, ctl(1'b0, 1'b1, 2'h0, capture_pkg::MODE_RISING));
    pulses(5'h01);
    bus(1'b0, capture_pkg::ADDR_CONTROL, 32'h0000_0000);
    cmp(32'(q[capture_pkg::POS_NOT_EMPTY]), 32'h0000_0001);
    cmp(32'(wakes > w0), 32'h0000_0001);
    drain();
    @(posedge clk);
    idle <= 1'b0;
    sleep <= 1'b1;
    w0 = wakes;
    bus(1'b1, capture_pkg::ADDR_CONTROL, ctl(1'b0, 1'b1, 2'h3, capture_pkg::MODE_WAKE_ONLY));
    bus(1'b1, capture_pkg::ADDR_STATUS, 32'h0000_0007);
    pulses(5'h01);
    bus(1'b0, capture_pkg::ADDR_STATUS, 32'h0000_0000);
    cmp(32'(q[capture_pkg::EVT_WAKE]), 32'h0000_0001);
    cmp(32'(wakes > w0), 32'h0000_0001);
    // Mid-run reset returns control and status to zero
    @(posedge clk);
    resetn <= 1'b0;
    sleep <= 1'b0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    bus(1'b0, capture_pkg::ADDR_CONTROL, 32'h0000_0000);
    cmp(q, 32'(capture_pkg::CONTROL_RESET));
    bus(1'b0, capture_pkg::ADDR_STATUS, 32'h0000_0000);
    cmp(q | 32'(irq), 32'h0000_0000);
    close_out();
  end
endmodule : input_capture_channel_tb
